// ==== rtl/blit_pkg.sv ====
// Constants, register map and field layout of the blit datapath
//==========================================================================
//==========================================================================
package blit_pkg;

    localparam int          DATA_W       = 16;
    localparam int          ADDR_W       = 4;

    // Register index map
    localparam logic [3:0]  REG_CTRL_A   = 4'h0;
    localparam logic [3:0]  REG_CTRL_B   = 4'h1;
    localparam logic [3:0]  REG_FW_MASK  = 4'h2;
    localparam logic [3:0]  REG_LW_MASK  = 4'h3;
    localparam logic [3:0]  REG_SIZE     = 4'h4;
    localparam logic [3:0]  REG_TEXTURE  = 4'h5;
    localparam logic [3:0]  REG_STATUS   = 4'h6;

    // Field positions
    localparam int          SHIFT_HI     = 15;
    localparam int          SHIFT_LO     = 12;
    localparam int          USE_HI       = 11;
    localparam int          USE_LO       = 8;
    localparam int          DEST_EN_BIT  = 8;
    localparam int          MINTERM_HI   = 7;
    localparam int          MINTERM_LO   = 0;
    localparam int          EFE_BIT      = 4;
    localparam int          IFE_BIT      = 3;
    localparam int          OCTANT_HI    = 4;
    localparam int          OCTANT_LO    = 2;
    localparam int          FCI_BIT      = 2;
    localparam int          DESC_BIT     = 1;
    localparam int          SINGLE_DOT_LINE_BIT     = 1;
    localparam int          LINE_BIT     = 0;
    localparam int          WIDTH_HI     = 5;
    localparam int          WIDTH_LO     = 0;
    localparam int          HEIGHT_HI    = 15;
    localparam int          HEIGHT_LO    = 6;
    localparam int          ZERO_BIT     = 13;
    localparam int          BUSY_BIT     = 14;

    // Reset values
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [15:0] MASK_RST     = 16'hffff;
    localparam logic [15:0] TEXTURE_RST  = 16'hffff;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BLIT = 2'b01,
        ST_LINE = 2'b10
    } eng_state_e;

endpackage

// ==== rtl/blit_shift_mask_fill_line.sv ====
// Blit engine: shifter, masks, minterm logic, area fill, zero flag and line mode
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module blit_shift_mask_fill_line
    import blit_pkg::*;
#(
    parameter int W = DATA_W
) (
    input  wire logic              sys_clk,        // 50 MHz system clock
    input  wire logic              rst_n,          // Synchronous reset, active low
    input  wire logic [ADDR_W-1:0] reg_addr,       // Register index
    input  wire logic [W-1:0]      reg_wdata,      // Register write data
    input  wire logic              reg_wr,         // Register write strobe
    input  wire logic              reg_rd,         // Register read strobe
    output logic      [W-1:0]      reg_rdata,      // Read data, cycle after strobe
    input  wire logic              src_valid,      // Fetched A/B/C words present
    input  wire logic [W-1:0]      src_a,          // Source A word
    input  wire logic [W-1:0]      src_b,          // Source B word
    input  wire logic [W-1:0]      src_c,          // Source C word
    input  wire logic              line_row_step,  // Row changes with this pixel
    output logic                   src_ready,      // Engine consumes sources
    output logic                   dest_write,     // Destination word write pulse
    output logic      [W-1:0]      dest_data,      // Destination word
    output logic                   descending,     // Address walk goes downward
    output logic      [2:0]        octant_code,    // Line octant code
    output logic                   blit_busy       // Operation in progress
);

    //======================================================================
    // Helpers
    //======================================================================
    function automatic logic [W-1:0] minterm(input logic [7:0] lf, input logic [W-1:0] a,
                                             input logic [W-1:0] b, input logic [W-1:0] c);
        logic [W-1:0] d;
        d = '0;
        for (int i = 0; i < W; i++) begin
            d[i] = lf[{a[i], b[i], c[i]}];
        end
        return d;
    endfunction

    // Barrel shift with bits carried in from the previous word
    function automatic logic [W-1:0] shifter(input logic [W-1:0] cur, input logic [W-1:0] prev,
                                             input logic [3:0] sh, input logic desc);
        logic [2*W-1:0] cat;
        cat = '0;
        if (desc) begin
            cat = {cur, prev} << sh;
            return cat[2*W-1:W];
        end
        cat = {prev, cur} >> sh;
        return cat[W-1:0];
    endfunction

    // Fill runs right to left; returns {carry out, filled word}
    function automatic logic [W:0] fill_word(input logic [W-1:0] d, input logic cin,
                                             input logic excl);
        logic [W-1:0] o;
        logic         st;
        o  = '0;
        st = cin;
        for (int i = 0; i < W; i++) begin
            st   = st ^ d[i];
            o[i] = excl ? st : (st | d[i]);
        end
        return {st, o};
    endfunction

    // Write decode shared by the start pulse and every register
    function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] idx);
        return wr && (addr == idx);
    endfunction

    //======================================================================
    // Registers
    //======================================================================
    logic [W-1:0] ctrl_a_r;
    logic [W-1:0] ctrl_b_r;
    logic [W-1:0] fw_mask_r;
    logic [W-1:0] lw_mask_r;
    logic [W-1:0] size_r;
    logic [W-1:0] texture_r;
    logic         zero_r;
    logic         start_wr;

    assign start_wr = wr_hit(reg_wr, reg_addr, REG_SIZE);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_a_r  <= CTRL_RST;
        end else if (wr_hit(reg_wr, reg_addr, REG_CTRL_A)) begin
            ctrl_a_r  <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_b_r  <= CTRL_RST;
        end else if (wr_hit(reg_wr, reg_addr, REG_CTRL_B)) begin
            ctrl_b_r  <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fw_mask_r <= MASK_RST;
        end else if (wr_hit(reg_wr, reg_addr, REG_FW_MASK)) begin
            fw_mask_r <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lw_mask_r <= MASK_RST;
        end else if (wr_hit(reg_wr, reg_addr, REG_LW_MASK)) begin
            lw_mask_r <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            size_r    <= CTRL_RST;
        end else if (start_wr) begin
            size_r    <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            texture_r <= TEXTURE_RST;
        end else if (wr_hit(reg_wr, reg_addr, REG_TEXTURE)) begin
            texture_r <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_STATUS: begin
                    reg_rdata           <= '0;
                    reg_rdata[ZERO_BIT] <= zero_r;
                    reg_rdata[BUSY_BIT] <= blit_busy;
                end
                default:    reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    //======================================================================
    // Field decode
    //======================================================================
    logic         line_mode;
    logic [3:0]   shift_a;
    logic [3:0]   shift_b;
    logic [7:0]   lf;
    logic         dest_en;
    logic         fill_incl;
    logic         fill_excl;
    logic         fill_cin;
    logic         single_dot;
    logic [6:0]   width_words;
    logic [10:0]  height_lines;

    assign line_mode    = ctrl_b_r[LINE_BIT];
    assign shift_a      = ctrl_a_r[SHIFT_HI:SHIFT_LO];
    assign shift_b      = ctrl_b_r[SHIFT_HI:SHIFT_LO];
    assign lf           = ctrl_a_r[MINTERM_HI:MINTERM_LO];
    assign dest_en      = ctrl_a_r[DEST_EN_BIT];
    assign fill_incl    = !line_mode && ctrl_b_r[IFE_BIT];
    assign fill_excl    = !line_mode && ctrl_b_r[EFE_BIT];
    assign fill_cin     = ctrl_b_r[FCI_BIT];
    assign single_dot   = line_mode && ctrl_b_r[SINGLE_DOT_LINE_BIT];
    assign descending   = !line_mode && ctrl_b_r[DESC_BIT];
    assign octant_code  = line_mode ? ctrl_b_r[OCTANT_HI:OCTANT_LO] : 3'h0;
    assign width_words  = {size_r[WIDTH_HI:WIDTH_LO] == 6'h00, size_r[WIDTH_HI:WIDTH_LO]};
    assign height_lines = {size_r[HEIGHT_HI:HEIGHT_LO] == 10'h000,
                           size_r[HEIGHT_HI:HEIGHT_LO]};

    //======================================================================
    // Engine control
    //======================================================================
    eng_state_e   state_r;
    logic [6:0]   word_cnt_r;
    logic [10:0]  line_cnt_r;
    logic         step;
    logic         last_word;
    logic         last_line;

    assign blit_busy = (state_r != ST_IDLE);
    assign src_ready = blit_busy;
    assign step      = blit_busy && src_valid;
    assign last_word = (word_cnt_r == width_words - 7'd1);
    assign last_line = (line_cnt_r == height_lines - 11'd1);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start_wr) begin
                        state_r <= ctrl_b_r[LINE_BIT] ? ST_LINE : ST_BLIT;
                    end
                end
                ST_BLIT: begin
                    if (step && last_word && last_line) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_LINE: begin
                    // One source word per pixel, so only the pixel count ends it
                    if (step && last_line) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || start_wr) begin
            word_cnt_r <= '0;
            line_cnt_r <= '0;
        end else if (step) begin
            if (state_r == ST_LINE || last_word) begin
                word_cnt_r <= '0;
                line_cnt_r <= line_cnt_r + 11'd1;
            end else begin
                word_cnt_r <= word_cnt_r + 7'd1;
            end
        end
    end

    //======================================================================
    // Block transfer datapath
    //======================================================================
    logic [W-1:0] prev_a_r;
    logic [W-1:0] prev_b_r;
    logic         carry_r;
    logic         first_word;
    logic [W-1:0] left_mask;
    logic [W-1:0] right_mask;
    logic [W-1:0] a_masked;
    logic [W-1:0] a_shift;
    logic [W-1:0] b_shift;
    logic [W-1:0] blit_logic;
    logic         line_cin;
    logic [W:0]   filled;
    logic [W-1:0] blit_result;

    assign first_word = (word_cnt_r == 7'd0);
    // Descending walks the line right to left, so its first word is the rightmost
    assign left_mask  = (descending ? last_word : first_word) ? fw_mask_r : '1;
    assign right_mask = (descending ? first_word : last_word) ? lw_mask_r : '1;
    assign a_masked   = src_a & left_mask & right_mask;
    assign a_shift    = shifter(a_masked, first_word ? '0 : prev_a_r, shift_a, descending);
    assign b_shift    = shifter(src_b, first_word ? '0 : prev_b_r, shift_b, descending);
    assign blit_logic = minterm(lf, a_shift, b_shift, src_c);
    assign line_cin   = first_word ? fill_cin : carry_r;
    assign filled     = fill_word(blit_logic, line_cin, fill_excl);
    assign blit_result = (fill_incl || fill_excl) ? filled[W-1:0] : blit_logic;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prev_a_r <= '0;
            prev_b_r <= '0;
            carry_r  <= 1'b0;
        end else if (step && state_r == ST_BLIT) begin
            prev_a_r <= a_masked;
            prev_b_r <= src_b;
            carry_r  <= filled[W];
        end
    end

    //======================================================================
    // Line drawing datapath
    //======================================================================
    logic [3:0]   pix_pos_r;
    logic [3:0]   tex_idx_r;
    logic         row_seen_r;
    logic [W-1:0] pix_word;
    logic [W-1:0] tex_word;
    logic [W-1:0] line_result;
    logic         line_plot;

    assign pix_word    = {1'b1, {(W-1){1'b0}}} >> pix_pos_r;
    assign tex_word    = {W{texture_r[4'd15 - tex_idx_r]}};
    // Minterms give regular or inverse video; texture all ones gives solid lines
    assign line_result = minterm(lf, pix_word, tex_word, src_c);
    assign line_plot   = !single_dot || !row_seen_r || line_row_step;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pix_pos_r  <= '0;
            tex_idx_r  <= '0;
            row_seen_r <= 1'b0;
        end else if (start_wr) begin
            pix_pos_r  <= shift_a;
            tex_idx_r  <= shift_b;
            row_seen_r <= 1'b0;
        end else if (step && state_r == ST_LINE) begin
            pix_pos_r  <= pix_pos_r + 4'd1;
            tex_idx_r  <= tex_idx_r + 4'd1;
            row_seen_r <= 1'b1;
        end
    end

    //======================================================================
    // Destination and zero flag
    //======================================================================
    logic [W-1:0] result;

    assign result = (state_r == ST_LINE) ? line_result : blit_result;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dest_write <= 1'b0;
            dest_data  <= '0;
        end else begin
            dest_write <= step && dest_en && (state_r != ST_LINE || line_plot);
            if (step) begin
                dest_data <= result;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            zero_r <= 1'b1;
        end else if (start_wr) begin
            zero_r <= 1'b1;
        end else if (step && (result != '0)) begin
            zero_r <= 1'b0;
        end
    end

endmodule

// ==== testbench/blit_monitor.sv ====
// Concurrent checks on the blit engine ports
`timescale 1ns/1ps
module blit_monitor
    import blit_pkg::*;
#(
    parameter int W = DATA_W
) (
    input wire logic              sys_clk,     // System clock
    input wire logic              rst_n,       // Reset, active low
    input wire logic [ADDR_W-1:0] reg_addr,    // Register index
    input wire logic              reg_wr,      // Write strobe
    input wire logic              reg_rd,      // Read strobe
    input wire logic [W-1:0]      reg_rdata,   // Read data
    input wire logic              src_valid,   // Source words present
    input wire logic              src_ready,   // Sources taken
    input wire logic              dest_write,  // Destination write pulse
    input wire logic [W-1:0]      dest_data,   // Destination word
    input wire logic              descending,  // Downward walk
    input wire logic [2:0]        octant_code, // Line octant
    input wire logic              blit_busy    // Operation running
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    //==================================================================
    // Register port and start
    wo_read_a: assert property (reg_rd && reg_addr != REG_STATUS |=> reg_rdata == '0)
        else $error("register read returned nonzero data");
    zero_start_a: assert property (
        (reg_wr && reg_addr == REG_SIZE) ##1 (reg_rd && reg_addr == REG_STATUS)
        |=> reg_rdata[ZERO_BIT] && reg_rdata[BUSY_BIT])
        else $error("status after start lacks zero or busy");
    start_busy_a: assert property (reg_wr && reg_addr == REG_SIZE |=> blit_busy)
        else $error("size write did not start the engine");
    busy_hold_a: assert property (blit_busy && !src_valid |=> blit_busy)
        else $error("busy ended without a word taken");
    busy_end_a: assert property ($fell(blit_busy) |-> $past(src_valid && src_ready))
        else $error("busy fell without a final word");
    //==================================================================
    // Destination stream and line direction
    dest_cause_a: assert property (dest_write |-> $past(src_valid && src_ready))
        else $error("destination write without a taken word");
    idle_quiet_a: assert property (!blit_busy && !$past(blit_busy) |-> !dest_write)
        else $error("destination write while idle");
    dest_hold_a: assert property (!$past(src_valid && src_ready) |-> $stable(dest_data))
        else $error("destination word changed without a taken word");
    line_dir_a: assert property (octant_code != 3'h0 |-> !descending)
        else $error("descending walk in line mode");
endmodule

// ==== testbench/dma_mem_model.sv ====
// Behavioural shared memory feeding source words by DMA
`timescale 1ns/1ps
module dma_mem_model (
    input  wire logic        sys_clk,   // System clock
    input  wire logic        rst_n,     // Reset, active low
    input  wire logic        src_ready, // Engine takes words
    input  wire logic        slow,      // Random fetch gaps
    input  wire logic [15:0] word_fix,  // Nonzero: same word on all sources
    output logic             src_valid, // Words present
    output logic      [15:0] src_a,     // Source A word
    output logic      [15:0] src_b,     // Source B word
    output logic      [15:0] src_c      // Source C word
);
    int seed = 64;

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            src_valid <= 1'b0;
            src_a     <= 16'h0;
            src_b     <= 16'h0;
            src_c     <= 16'h0;
        end else if (src_ready && (!slow || ($random(seed) % 2) != 0)) begin
            src_valid <= 1'b1;
            src_a     <= (word_fix != 16'h0) ? word_fix : 16'($random(seed));
            src_b     <= (word_fix != 16'h0) ? word_fix : 16'($random(seed));
            src_c     <= (word_fix != 16'h0) ? word_fix : 16'($random(seed));
        end else begin
            // No stale word left on the bus between fetches
            src_valid <= 1'b0;
            src_a     <= ~src_a;
            src_b     <= ~src_b;
            src_c     <= ~src_c;
        end
    end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the blit engine
`timescale 1ns/1ps
module tb;
    import blit_pkg::*;
    logic        sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, line_row_step = 0, slow = 0;
    logic [3:0]  reg_addr = 0, pos, tidx;
    logic [15:0] reg_wdata = 0, word_fix = 0, reg_rdata, src_a, src_b, src_c, dest_data;
    logic        src_valid, src_ready, dest_write, descending, blit_busy;
    logic [2:0]  octant_code;
    logic [15:0] ca = 0, cb = 0, fwm = 16'hffff, lwm = 16'hffff, tex = 16'hffff;
    logic [15:0] exp_d, rd_v, pa, pb;
    logic        fs, zf = 1, first, exp_w, pend = 0;
    int          seed = 64, n_mismatch = 0, compares = 0, wid = 1, total, nword, i, kd;

    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) line_row_step <= ($random(seed) % 2) != 0;

    blit_shift_mask_fill_line blit_shift_mask_fill_line_inst (.sys_clk, .rst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .src_valid, .src_a, .src_b, .src_c,
        .line_row_step, .src_ready, .dest_write, .dest_data, .descending, .octant_code,
        .blit_busy);
    dma_mem_model dma_mem_model_inst (.sys_clk, .rst_n, .src_ready, .slow, .word_fix,
        .src_valid, .src_a, .src_b, .src_c);

    //==================================================================
    // Expected-value functions and checks
    function automatic logic [15:0] mt(logic [15:0] a, b, c, logic [7:0] lf);
        for (int k = 0; k < 16; k++) mt[k] = lf[{a[k], b[k], c[k]}];
    endfunction
    function automatic logic [15:0] shf(logic [15:0] cur, prv, logic [3:0] s, logic d);
        logic [31:0] t;
        t = d ? ({cur, prv} << s) : ({prv, cur} >> s);
        return d ? t[31:16] : t[15:0];
    endfunction
    function automatic logic [15:0] fill(logic [15:0] r, logic ex);
        for (int k = 0; k < 16; k++) begin
            fs = fs ^ r[k];
            fill[k] = ex ? fs : (fs | r[k]);
        end
    endfunction
    task automatic chk(logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    //==================================================================
    // Register bus tasks
    task automatic wr(logic [3:0] a, logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        case (a)
            REG_CTRL_A: ca = d;
            REG_CTRL_B: cb = d;
            REG_FW_MASK: fwm = d;
            REG_LW_MASK: lwm = d;
            REG_TEXTURE: tex = d;
            default: ;
        endcase
        if (a == REG_SIZE) begin
            wid = (d[5:0] == 0) ? 64 : d[5:0];
            total = (cb[0] ? 1 : wid) * ((d[15:6] == 0) ? 1024 : d[15:6]);
            nword = 0;
            zf = 1;
            pos = ca[15:12];
            tidx = cb[15:12];
            first = 1;
        end
        @(posedge sys_clk);
    endtask
    task automatic rd(logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
    task automatic run(logic [15:0] sz);
        int n;
        wr(REG_SIZE, sz);
        rd(REG_STATUS, rd_v);
        chk(rd_v[14:13], 2'b11);
        chk(octant_code, cb[0] ? cb[4:2] : 3'h0);
        chk(descending, cb[0] ? 1'b0 : cb[1]);
        n = 0;
        while (blit_busy && n < 5000) begin
            @(negedge sys_clk);
            n++;
        end
        chk(blit_busy, 1'b0);
        @(posedge sys_clk);
        chk(16'(nword), 16'(total));
        rd(REG_STATUS, rd_v);
        chk(rd_v[14:13], {1'b0, zf});
    endtask

    //==================================================================
    // Reference model of each taken word
    always @(posedge sys_clk) begin
        logic [15:0] am, a, b, r;
        int col;
        if (rst_n) chk(dest_write, pend && exp_w);
        if (pend && kd == 0) chk(dest_data, exp_d);
        if (pend && kd == 1) chk(dest_data, exp_d);
        if (pend && kd == 2) chk(dest_data, exp_d);
        pend = 0;
        if (rst_n && src_valid && src_ready) begin
            col = nword % wid;
            if (col == 0) begin
                pa = 0;
                pb = 0;
                fs = cb[2];
            end
            if (cb[0]) begin
                a = 16'h8000 >> pos;
                b = {16{tex[4'hf - tidx]}};
                exp_w = ca[8] && (!cb[1] || first || line_row_step);
                pos++;
                tidx++;
                first = 0;
                kd = 2;
            end else begin
                am = src_a;
                if (col == 0) am &= cb[1] ? lwm : fwm;
                if (col == wid - 1) am &= cb[1] ? fwm : lwm;
                a = shf(am, pa, ca[15:12], cb[1]);
                b = shf(src_b, pb, cb[15:12], cb[1]);
                pa = am;
                pb = src_b;
                exp_w = ca[8];
                kd = (cb[4:3] != 2'b00) ? 1 : 0;
            end
            r = mt(a, b, src_c, ca[7:0]);
            exp_d = (kd == 1) ? fill(r, cb[4]) : r;
            if (exp_d != 0) zf = 0;
            pend = 1;
            nword++;
        end
    end

    //==================================================================
    // Scenarios
    initial begin
        #1000000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (i = 0; i < 16; i++) begin
            if (i != REG_STATUS) rd(4'(i), rd_v);
            if (i != REG_STATUS) chk(rd_v, 16'h0);
        end
        rd(REG_STATUS, rd_v);
        chk(rd_v[14:13], 2'b01);
        for (i = 0; i < 24; i++) begin
            slow <= i[0];
            wr(REG_CTRL_A, (i == 0) ? 16'hf1ca : 16'($random(seed)));
            wr(REG_CTRL_B, (i == 1) ? 16'h0002 : (16'($random(seed)) & 16'hf01e));
            if (i > 0) wr(REG_FW_MASK, i[1] ? 16'hffff : 16'($random(seed)));
            if (i > 0) wr(REG_LW_MASK, i[2] ? 16'hffff : 16'($random(seed)));
            run({10'(1 + i % 3), 6'(1 + i % 4)});
        end
        run({10'd1, 6'd0});
        word_fix <= 16'h0810;
        wr(REG_CTRL_A, 16'h01f0);
        for (i = 0; i < 4; i++) begin
            wr(REG_CTRL_B, {11'h0, i[1], ~i[1], i[0], 2'b10});
            run({10'd2, 6'd2});
        end
        word_fix <= 16'h0;
        for (i = 0; i < 8; i++) begin
            wr(REG_TEXTURE, 16'($random(seed)));
            wr(REG_CTRL_A, {4'($random(seed)), 4'hb, 8'($random(seed))});
            wr(REG_CTRL_B, {(i == 0) ? 4'h0 : 4'($random(seed)), 7'h0, 3'(i), i[0], 1'b1});
            run({10'(2 + i), 6'd2});
        end
        run({10'd0, 6'd2});
        print_verdict;
    end
endmodule

bind blit_shift_mask_fill_line blit_monitor #(.W(W)) blit_monitor_inst (.sys_clk, .rst_n,
    .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .src_valid, .src_ready, .dest_write,
    .dest_data, .descending, .octant_code, .blit_busy);
